// *** hdl/eedr_defs.vh ***
`ifndef EEDR_DEFS_VH
`define EEDR_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define EEDR_IDX_ENGINE_ENABLE 10'h00B
`define EEDR_IDX_LEVEL_A 10'h00C
`define EEDR_IDX_LEVEL_B 10'h00D
`define EEDR_IDX_LEVEL_C 10'h00E
`define EEDR_IDX_LIMITER_STATUS 10'h03F

// Engine enable register layout and reset value; level register reset value.
`define EEDR_BIT_CLK_GATE 0
`define EEDR_BIT_LIMITER_ON 1
`define EEDR_ENABLE_RESET 8'h03
`define EEDR_LEVEL_RESET 8'h00

// Biquad coefficient window in parameter memory.
`define EEDR_COEF_FIRST 10'h0E0
`define EEDR_COEF_LAST 10'h2BF

// Limiter gain range and decay step.
`define EEDR_GAIN_MAX 8'hFF
`define EEDR_DECAY_STEP 8'h01

// Level engine select codes.
`define EEDR_SEL_A 2'h0
`define EEDR_SEL_B 2'h1
`define EEDR_SEL_C 2'h2

// Linear-to-dB conversion: a 24-bit magnitude, leading one below this bit is the floor.
`define EEDR_LIN_W 24
`define EEDR_FLOOR_POS 5'h08
`define EEDR_FRAC_W 4

`endif

// *** hdl/eedr_db_conv.v ***
`timescale 1ns/10ps
`include "eedr_defs.vh"

// Converts a linear magnitude (full scale 2^24) to a level code of 16 steps per 6 dB.
// Code 0 is -96 dB; the top code is one 0.375 dB step below full scale.
module eedr_db_conv (
   input wire [`EEDR_LIN_W-1:0] linear_in, // Linear magnitude from the engine
   output reg [7:0] level_code_out // Level code in 0.375 dB steps
);

   reg [4:0] lead_pos;
   reg lead_found;
   reg [3:0] mant;
   reg [4:0] octave;
   integer i;

   always @*
   begin
      lead_pos = 5'h00;
      lead_found = 1'b0;
      mant = 4'h0;
      octave = 5'h00;
      level_code_out = 8'h00;
      for (i = 0; i < `EEDR_LIN_W; i = i + 1)
      begin
         if (linear_in[i])
         begin
            lead_pos = i[4:0];
            lead_found = 1'b1;
         end
      end
      // Four bits below the leading one interpolate inside the octave.
      if (lead_found && lead_pos >= `EEDR_FLOOR_POS)
      begin
         mant = linear_in[lead_pos-1 -: `EEDR_FRAC_W];
         octave = lead_pos - `EEDR_FLOOR_POS;
         level_code_out = {octave[3:0], mant};
      end
   end

endmodule

// *** hdl/eedr_top.v ***
// Function
// - Limiter off suppresses attack; decay runs whenever the clock gate is on.
// - Limiter enable bit 1, resets 1; off means max gain.
// - Clock gate bit 0, resets 1, gates engine immediately.
// - Coefficient writes 0x0E0-0x2BF blocked while gate off.
// - Engine writes levels 0x0C-0x0E, converted to dB.
// - Level registers 8-bit, read-only, reset 0x00.
// - Code 0 is -96 dB, 16 codes per 6 dB.
// - Intended for rms measurement by engine program.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "eedr_defs.vh"

module eedr_top (
   input wire clk_in, // System clock, 250 MHz
   input wire rst_n_in, // Synchronous reset, active low
   // Avalon-MM slave
   input wire [11:0] avs_address, // Byte address
   input wire avs_read, // Read request
   input wire avs_write, // Write request
   input wire [31:0] avs_writedata, // Write data
   input wire [3:0] avs_byteenable, // Byte enables
   output reg [31:0] avs_readdata, // Read data
   output wire avs_waitrequest, // Stall while request pending
   // Engine clock gate
   output wire engine_clk_gate_out, // High lets the engine clock run
   // Engine level writes
   input wire level_wr_in, // Engine writes a level register
   input wire [1:0] level_sel_in, // Which level register
   input wire [`EEDR_LIN_W-1:0] level_lin_in, // Linear magnitude
   output wire [7:0] level_code_a_out, // Level code A
   output wire [7:0] level_code_b_out, // Level code B
   output wire [7:0] level_code_c_out, // Level code C
   // Limiter
   input wire lim_attack_in, // Attack request pulse
   input wire [7:0] lim_attack_gain_in, // Gain the attack asks for
   input wire lim_decay_in, // Decay step pulse
   output wire limiter_on_out, // Limiter enable level
   output reg [7:0] lim_gain_out, // Gain applied by limiter instructions
   // Host parameter memory writes
   input wire coef_wr_in, // Host parameter write request
   input wire [9:0] coef_addr_in, // Parameter memory address
   input wire [31:0] coef_data_in, // Parameter data
   output reg coef_wr_out, // Write forwarded to parameter memory
   output reg [9:0] coef_addr_out, // Forwarded address
   output reg [31:0] coef_data_out, // Forwarded data
   output reg coef_blocked_out // Pulse: a write was refused
);

   reg [7:0] enable_r;
   reg [7:0] enable_nxt;
   reg [7:0] level_a_r;
   reg [7:0] level_b_r;
   reg [7:0] level_c_r;
   reg [7:0] gain_r;
   reg [7:0] gain_nxt;
   reg ack_r;
   reg [31:0] rdata_nxt;
   wire [9:0] reg_idx;
   wire req;
   wire wr_take;
   wire [7:0] level_conv;
   wire clk_gate;
   wire limiter_on;

   // Index of the addressed register.
   function [9:0] word_index;
      input [11:0] addr;
      begin
         word_index = addr[11:2];
      end
   endfunction

   // True for addresses holding biquad coefficients.
   function in_coef_window;
      input [9:0] addr;
      begin
         in_coef_window = (addr >= `EEDR_COEF_FIRST) && (addr <= `EEDR_COEF_LAST);
      end
   endfunction

   // Saturating increase toward maximum gain.
   function [7:0] gain_step_up;
      input [7:0] g;
      reg [8:0] sum;
      begin
         sum = {1'b0, g} + {1'b0, `EEDR_DECAY_STEP};
         if (sum > {1'b0, `EEDR_GAIN_MAX})
         begin
            gain_step_up = `EEDR_GAIN_MAX;
         end
         else
         begin
            gain_step_up = sum[7:0];
         end
      end
   endfunction

   assign reg_idx = word_index(avs_address);
   assign req = avs_read | avs_write;
   // Every request waits exactly one cycle; it is accepted on the edge after.
   assign avs_waitrequest = req & ~ack_r;
   assign wr_take = avs_write & ack_r;

   assign clk_gate = enable_r[`EEDR_BIT_CLK_GATE];
   assign limiter_on = enable_r[`EEDR_BIT_LIMITER_ON];
   // The gate bit drives the clock gate with no sync stage so it acts at once.
   assign engine_clk_gate_out = clk_gate;
   assign limiter_on_out = limiter_on;

   assign level_code_a_out = level_a_r;
   assign level_code_b_out = level_b_r;
   assign level_code_c_out = level_c_r;

   eedr_db_conv u_conv (
      .linear_in(level_lin_in),
      .level_code_out(level_conv)
   );

   // Bus handshake.
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data is latched as the wait drops so it stands on the accepting edge.
   always @*
   begin
      rdata_nxt = 32'h0000_0000;
      case (reg_idx)
         `EEDR_IDX_ENGINE_ENABLE:
         begin
            rdata_nxt = {24'h00_0000, enable_r};
         end
         `EEDR_IDX_LEVEL_A:
         begin
            rdata_nxt = {24'h00_0000, level_a_r};
         end
         `EEDR_IDX_LEVEL_B:
         begin
            rdata_nxt = {24'h00_0000, level_b_r};
         end
         `EEDR_IDX_LEVEL_C:
         begin
            rdata_nxt = {24'h00_0000, level_c_r};
         end
         `EEDR_IDX_LIMITER_STATUS:
         begin
            rdata_nxt = {24'h00_0000, gain_r};
         end
         default:
         begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if (avs_read && !ack_r)
      begin
         avs_readdata <= rdata_nxt;
      end
   end

   // Engine enable register; all eight bits are stored, reserved ones included.
   always @*
   begin
      enable_nxt = enable_r;
      if (wr_take && reg_idx == `EEDR_IDX_ENGINE_ENABLE && avs_byteenable[0])
      begin
         enable_nxt = avs_writedata[7:0];
      end
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         enable_r <= `EEDR_ENABLE_RESET;
      end
      else
      begin
         enable_r <= enable_nxt;
      end
   end

   // Level registers take only engine writes; bus writes to them do nothing.
   // The engine cannot write while its clock is gated off.
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         level_a_r <= `EEDR_LEVEL_RESET;
         level_b_r <= `EEDR_LEVEL_RESET;
         level_c_r <= `EEDR_LEVEL_RESET;
      end
      else if (level_wr_in && clk_gate)
      begin
         case (level_sel_in)
            `EEDR_SEL_A:
            begin
               level_a_r <= level_conv;
            end
            `EEDR_SEL_B:
            begin
               level_b_r <= level_conv;
            end
            `EEDR_SEL_C:
            begin
               level_c_r <= level_conv;
            end
            default:
            begin
               level_a_r <= level_a_r;
            end
         endcase
      end
   end

   // Limiter gain: attack only pulls the gain down while the limiter is on.
   // Decay keeps walking the tracked gain back up even while the limiter is off,
   // so switching it off mid-decay is smooth; the output mux below holds the
   // applied gain at maximum meanwhile.
   always @*
   begin
      gain_nxt = gain_r;
      // Attack takes priority over a decay step in the same cycle.
      if (limiter_on && lim_attack_in && lim_attack_gain_in < gain_r)
      begin
         gain_nxt = lim_attack_gain_in;
      end
      else if (lim_decay_in)
      begin
         gain_nxt = gain_step_up(gain_r);
      end
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         gain_r <= `EEDR_GAIN_MAX;
      end
      else if (clk_gate)
      begin
         gain_r <= gain_nxt;
      end
   end

   // Applied gain: the tracked gain while on, the fixed maximum while off.
   always @*
   begin
      if (limiter_on)
      begin
         lim_gain_out = gain_r;
      end
      else
      begin
         lim_gain_out = `EEDR_GAIN_MAX;
      end
   end

   // Parameter memory write filter; coefficient writes need the clock gate set.
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         coef_wr_out <= 1'b0;
         coef_addr_out <= 10'h000;
         coef_data_out <= 32'h0000_0000;
         coef_blocked_out <= 1'b0;
      end
      else
      begin
         coef_wr_out <= 1'b0;
         coef_blocked_out <= 1'b0;
         if (coef_wr_in)
         begin
            if (in_coef_window(coef_addr_in) && !clk_gate)
            begin
               coef_blocked_out <= 1'b1;
            end
            else
            begin
               coef_wr_out <= 1'b1;
               coef_addr_out <= coef_addr_in;
               coef_data_out <= coef_data_in;
            end
         end
      end
   end

endmodule

// *** sim/eedr_chk.sv ***
`timescale 1ns/10ps
module eedr_chk (
   input wire clk_in, // Clock
   input wire rst_n_in, // Reset
   input wire avs_read, // Read
   input wire avs_write, // Write
   input wire avs_waitrequest, // Stall
   input wire [31:0] avs_readdata, // Read data
   input wire engine_clk_gate_out, // Gate
   input wire limiter_on_out, // Limiter
   input wire [7:0] lim_gain_out, // Gain
   input wire lim_attack_in, // Attack
   input wire [7:0] lim_attack_gain_in, // Attack gain
   input wire lim_decay_in, // Decay
   input wire coef_wr_in, // Write in
   input wire [9:0] coef_addr_in, // Address in
   input wire coef_wr_out, // Forwarded
   input wire coef_blocked_out, // Refused
   input wire [7:0] level_code_a_out // Level A
);
   wire blk = coef_wr_in && !engine_clk_gate_out && coef_addr_in >= 10'h0E0 && coef_addr_in <= 10'h2BF;
   wire run = limiter_on_out && engine_clk_gate_out;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait too long");
   a_rdata_high: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_coef_block: assert property (blk |=> coef_blocked_out && !coef_wr_out)
      else $error("coefficient write not refused");
   a_coef_pass: assert property (coef_wr_in && !blk |=> coef_wr_out && !coef_blocked_out)
      else $error("coefficient write not forwarded");
   a_block_cause: assert property (coef_blocked_out |-> $past(blk))
      else $error("refusal without cause");
   a_lim_off_max: assert property (!limiter_on_out |-> lim_gain_out == 8'hFF)
      else $error("gain not maximum while off");
   a_decay_step: assert property (run && lim_decay_in && !lim_attack_in && lim_gain_out != 8'hFF ##1 limiter_on_out
      |-> lim_gain_out == $past(lim_gain_out) + 8'h01)
      else $error("decay step wrong");
   a_attack_take: assert property (run && lim_attack_in && lim_attack_gain_in < lim_gain_out ##1 limiter_on_out
      |-> lim_gain_out == $past(lim_attack_gain_in))
      else $error("attack gain not taken");
   a_level_frozen: assert property (!engine_clk_gate_out |=> $stable(level_code_a_out))
      else $error("level changed with clock gated");
   cover property (blk);
   cover property (run && lim_attack_in);
   cover property (avs_read && !avs_waitrequest);
endmodule
bind eedr_top eedr_chk chk_i (
   .clk_in(clk_in),
   .rst_n_in(rst_n_in),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .avs_readdata(avs_readdata),
   .engine_clk_gate_out(engine_clk_gate_out),
   .limiter_on_out(limiter_on_out),
   .lim_gain_out(lim_gain_out),
   .lim_attack_in(lim_attack_in),
   .lim_attack_gain_in(lim_attack_gain_in),
   .lim_decay_in(lim_decay_in),
   .coef_wr_in(coef_wr_in),
   .coef_addr_in(coef_addr_in),
   .coef_wr_out(coef_wr_out),
   .coef_blocked_out(coef_blocked_out),
   .level_code_a_out(level_code_a_out)
);

// *** sim/test_engine_enable_db_readout.sv ***
`timescale 1ns/10ps
module test_engine_enable_db_readout;
   reg clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [11:0] avs_address = 12'h000;
   reg avs_read = 1'b0, avs_write = 1'b0, level_wr_in = 1'b0, lim_attack_in = 1'b0, lim_decay_in = 1'b0;
   reg coef_wr_in = 1'b0;
   reg [31:0] avs_writedata = 32'h0000_0000, coef_data_in = 32'h0000_0000;
   reg [3:0] avs_byteenable = 4'hF;
   reg [1:0] level_sel_in = 2'h0;
   reg [23:0] level_lin_in = 24'h00_0000;
   reg [7:0] lim_attack_gain_in = 8'h00;
   reg [9:0] coef_addr_in = 10'h000;
   wire [31:0] avs_readdata, coef_data_out;
   wire [9:0] coef_addr_out;
   wire [7:0] level_code_a_out, level_code_b_out, level_code_c_out, lim_gain_out;
   wire avs_waitrequest, engine_clk_gate_out, limiter_on_out, coef_wr_out, coef_blocked_out;
   reg [31:0] rd;
   integer n_mismatch = 0;
   integer n_tests = 0;
   eedr_top uut (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .engine_clk_gate_out(engine_clk_gate_out),
      .level_wr_in(level_wr_in),
      .level_sel_in(level_sel_in),
      .level_lin_in(level_lin_in),
      .level_code_a_out(level_code_a_out),
      .level_code_b_out(level_code_b_out),
      .level_code_c_out(level_code_c_out),
      .lim_attack_in(lim_attack_in),
      .lim_attack_gain_in(lim_attack_gain_in),
      .lim_decay_in(lim_decay_in),
      .limiter_on_out(limiter_on_out),
      .lim_gain_out(lim_gain_out),
      .coef_wr_in(coef_wr_in),
      .coef_addr_in(coef_addr_in),
      .coef_data_in(coef_data_in),
      .coef_wr_out(coef_wr_out),
      .coef_addr_out(coef_addr_out),
      .coef_data_out(coef_data_out),
      .coef_blocked_out(coef_blocked_out)
   );
   always #2 clk_in = ~clk_in;
   task test_done;
   begin
      if (n_mismatch == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // The request stands until waitrequest is sampled low at a rising edge; that edge takes it and its read data.
   task bus(input wr, input [11:0] a, input [7:0] d, input [3:0] be);
   begin
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk_in);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clk_in);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_in);
   end
   endtask
   task rdchk(input [11:0] a, input [7:0] e);
   begin
      bus(1'b0, a, 8'h00, 4'hF);
      chk(rd, {24'h00_0000, e});
   end
   endtask
   task lvl(input [1:0] s, input [23:0] v);
   begin
      level_sel_in <= s;
      level_lin_in <= v;
      level_wr_in <= 1'b1;
      @(posedge clk_in);
      level_wr_in <= 1'b0;
      @(posedge clk_in);
   end
   endtask
   task coef(input [9:0] a, input f);
   begin
      coef_addr_in <= a;
      coef_data_in <= {22'h00_0000, a} + 32'h5A00_0000;
      coef_wr_in <= 1'b1;
      @(posedge clk_in);
      coef_wr_in <= 1'b0;
      @(negedge clk_in);
      chk({6'h00, coef_wr_out, coef_blocked_out}, {6'h00, f, !f});
      if (f)
      begin
         chk(coef_addr_out, a);
         chk(coef_data_out, {22'h00_0000, a} + 32'h5A00_0000);
      end
      @(posedge clk_in);
   end
   endtask
   task lim(input att, input [7:0] g, input dec, input [7:0] e);
   begin
      lim_attack_in <= att;
      lim_attack_gain_in <= g;
      lim_decay_in <= dec;
      @(posedge clk_in);
      lim_attack_in <= 1'b0;
      lim_decay_in <= 1'b0;
      @(negedge clk_in);
      chk(lim_gain_out, e);
      @(posedge clk_in);
   end
   endtask
   task t_reset;
   begin
      rdchk(12'h02C, 8'h03);
      rdchk(12'h030, 8'h00);
      rdchk(12'h034, 8'h00);
      rdchk(12'h038, 8'h00);
      chk({6'h00, limiter_on_out, engine_clk_gate_out}, 8'h03);
      chk(lim_gain_out, 8'hFF);
   end
   endtask
   task t_levels;
      integer k, s;
      reg [23:0] lin_t [0:3];
      reg [7:0] code_t [0:3];
   begin
      lin_t[0] = 24'h00_0100;
      code_t[0] = 8'h00;
      lin_t[1] = 24'h00_0300;
      code_t[1] = 8'h18;
      lin_t[2] = 24'h80_0000;
      code_t[2] = 8'hF0;
      lin_t[3] = 24'hFF_FFFF;
      code_t[3] = 8'hFF;
      for (k = 0; k < 4; k = k + 1)
         for (s = 0; s < 3; s = s + 1)
         begin
            lvl(s[1:0], lin_t[k]);
            chk(s == 0 ? level_code_a_out : s == 1 ? level_code_b_out : level_code_c_out, code_t[k]);
            rdchk({s[9:0], 2'b00} + 12'h030, code_t[k]);
         end
      lvl(2'h3, 24'h00_0100);
      rdchk(12'h030, 8'hFF);
      bus(1'b1, 12'h030, 8'h55, 4'hF);
      rdchk(12'h030, 8'hFF);
      rdchk(12'h100, 8'h00);
   end
   endtask
   task t_gate;
   begin
      bus(1'b1, 12'h02C, 8'hFC, 4'hF);
      chk({6'h00, limiter_on_out, engine_clk_gate_out}, 8'h00);
      rdchk(12'h02C, 8'hFC);
      lvl(2'h0, 24'h00_0100);
      chk(level_code_a_out, 8'hFF);
      coef(10'h0DF, 1'b1);
      coef(10'h0E0, 1'b0);
      coef(10'h2BF, 1'b0);
      coef(10'h2C0, 1'b1);
      bus(1'b1, 12'h02C, 8'h01, 4'h0);
      rdchk(12'h02C, 8'hFC);
      bus(1'b1, 12'h02C, 8'h01, 4'hF);
      coef(10'h0E0, 1'b1);
   end
   endtask
   task t_limit;
   begin
      lim(1'b1, 8'h40, 1'b1, 8'hFF);
      rdchk(12'h0FC, 8'hFF);
      bus(1'b1, 12'h02C, 8'h03, 4'hF);
      lim(1'b1, 8'h40, 1'b0, 8'h40);
      lim(1'b0, 8'h00, 1'b1, 8'h41);
      rdchk(12'h0FC, 8'h41);
      bus(1'b1, 12'h02C, 8'h01, 4'hF);
      lim(1'b0, 8'h00, 1'b1, 8'hFF);
      lim(1'b1, 8'h10, 1'b0, 8'hFF);
      rdchk(12'h0FC, 8'h42);
      bus(1'b1, 12'h02C, 8'h03, 4'hF);
      lim(1'b0, 8'h00, 1'b1, 8'h43);
      lim(1'b1, 8'h20, 1'b1, 8'h20);
   end
   endtask
   initial
   begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset;
      t_levels;
      t_gate;
      t_limit;
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset;
      test_done;
   end
   initial
   begin
      #20000;
      n_mismatch = n_mismatch + 1;
      test_done;
   end
endmodule
